// ===== bench/arith_logic_execute_tb.sv
// self-checking bench of the execute datapath against an integer model
`timescale 1ns/10ps
`default_nettype none
`define CK(a, e) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
	$display("wrong value at %0t: got %h exp %h", $time, a, e); end end
module mcu_arith_logic_execute_tb;
	logic mclk_i = 1'b0;
	logic srst_i = 1'b1;
	logic ce_i = 1'b1;
	logic req_valid_i = 1'b0;
	exec_pkg::exec_req_s req_i = '0;
	exec_pkg::io_cmd_s io_cmd_i = '0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [7:0] evt_i = 8'h00;
	logic req_ready_o, io_rd_valid_o, skip_o, skip_valid_o, io_err_o;
	exec_pkg::exec_res_s res_o;
	logic [7:0] flags_o, io_rdata_o, reg_rdata_o;
	logic [15:0] pair, pc;
	logic [7:0] model_flags;
	int fail_count = 0;
	int total_checks = 0;
	int seed = 9;

	always #50 mclk_i = ~mclk_i;

	arith_logic_execute i_arith_logic_execute (.mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ce_i),
		.req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o), .res_o(res_o),
		.flags_o(flags_o), .io_cmd_i(io_cmd_i), .io_rdata_o(io_rdata_o),
		.io_rd_valid_o(io_rd_valid_o), .skip_o(skip_o), .skip_valid_o(skip_valid_o),
		.io_err_o(io_err_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .evt_i(evt_i));
	exec_partner i_exec_partner (.mclk_i(mclk_i), .res_i(res_o), .pair_o(pair), .pc_o(pc));

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// op codes as integers; b doubles as register and immediate operand
	task automatic mdl(input int o, a, b, h, output int d);
		int r, cc, w, p, sa, sb;
		logic [7:0] f;
		f = model_flags;
		cc = (o == 2 || o == 6 || o == 7) ? int'(f[0]) : 0;
		r = 0;
		d = 0;
		w = h * 256 + a;
		sa = a > 127 ? a - 256 : a;
		sb = b > 127 ? b - 256 : b;
		case (o)
			1, 2: begin
				r = a + b + cc;
				f[0] = r[8];
				f[5] = (a % 16 + b % 16 + cc) > 15;
				f[3] = a[7] == b[7] && r[7] != a[7];
			end
			4, 5, 6, 7, 15: begin
				if (o == 15) begin
					b = a;
					a = 0;
				end
				r = a - b - cc;
				f[0] = a < b + cc;
				f[5] = a % 16 < b % 16 + cc;
				f[3] = a[7] != b[7] && r[7] != a[7];
			end
			9, 10, 11, 12, 13, 14, 16, 17, 20, 21: begin
				r = o < 11 ? a & b : o < 13 || o == 16 ? a | b : o == 13 ? a ^ b : o == 17 ?
					a & ~b : o == 20 ? a : o == 21 ? 0 : ~a;
				f[3] = 1'b0;
				if (o == 14) f[0] = 1'b1;
			end
			18, 19: begin
				r = o == 18 ? a + 1 : a - 1;
				f[3] = o == 18 ? a == 127 : a == 128;
			end
			3, 8: begin
				r = o == 3 ? w + b % 64 : w - b % 64;
				f[0] = o == 3 ? r[16] : b % 64 > w;
				f[3] = o == 3 ? !w[15] && r[15] : w[15] && !r[15];
				d = r & 65535;
				f[1] = d == 0;
				f[2] = d[15];
				f[4] = f[2] ^ f[3];
			end
			23, 24, 25, 26, 27, 28: begin
				p = (o == 23 || o == 26) ? a * b : (o == 24 || o == 27) ? sa * sb : sa * b;
				p = p & 65535;
				f[0] = p[15];
				d = o > 25 ? (p << 1) & 65535 : p;
				f[1] = d == 0;
			end
			22: d = 255;
			default: d = w;
		endcase
		if (o < 3 || (o > 3 && o < 8) || (o > 8 && o < 22)) begin
			d = r & 255;
			f[1] = d == 0 && (!(o == 6 || o == 7) || f[1]);
			f[2] = d[7];
			f[4] = f[2] ^ f[3];
		end
		model_flags = f;
	endtask

	task automatic ex(input int o, a, b, h);
		int d, n;
		@(posedge mclk_i);
		req_valid_i <= 1'b1;
		req_i <= {o[4:0], a[7:0], b[7:0], h[7:0], b[7:0], h[7:0], a[7:0]};
		@(posedge mclk_i);
		req_valid_i <= 1'b0;
		mdl(o, a, b, h, d);
		for (n = 0; n < 3; n++) begin
			#1;
			if (n == 0) `CK(req_ready_o, !(o == 3 || o == 8 || o > 22))
			if (res_o.valid === 1'b1) break;
			@(posedge mclk_i);
		end
		if (n == 3) begin
			fail_count++;
			$display("wrong value at %0t: no result", $time);
			summarize();
		end
		`CK(n, int'(o == 3 || o == 8 || o > 22))
		`CK(res_o.data, d[15:0])
		`CK({res_o.word, res_o.product, res_o.pc_load}, {o == 3 || o == 8, o > 22 && o < 29, o == 29})
		`CK(flags_o, model_flags)
		if (o > 22) begin
			@(posedge mclk_i);
			#1;
			`CK(o == 29 ? pc : pair, d[15:0])
		end
	endtask

	task automatic rg(input logic wr, input logic [7:0] ad, wd);
		@(posedge mclk_i);
		reg_wr_i <= wr;
		reg_rd_i <= !wr;
		reg_addr_i <= ad;
		reg_wdata_i <= wd;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
		reg_rd_i <= 1'b0;
		#1;
	endtask

	task automatic io(input logic [2:0] kd, input logic [5:0] ad, input logic [2:0] bt,
		input logic [7:0] wd);
		@(posedge mclk_i);
		io_cmd_i <= {1'b1, kd, ad, bt, wd};
		@(posedge mclk_i);
		io_cmd_i.valid <= 1'b0;
		#1;
	endtask

	initial begin
		int o, i, a, b, h;
		repeat (20) @(posedge mclk_i);
		srst_i <= 1'b0;
		io(3'h1, 6'h3F, 3'h0, 8'h15);
		rg(1'b0, 8'h5F, 8'h00);
		`CK(reg_rdata_o, 8'h15)
		model_flags = 8'h15;
		rg(1'b1, 8'h3D, 8'hA0);
		io(3'h2, 6'h1D, 3'h3, 8'h00);
		io(3'h3, 6'h1D, 3'h7, 8'h00);
		io(3'h4, 6'h1D, 3'h3, 8'h00);
		`CK({skip_valid_o, skip_o}, 2'b11)
		io(3'h5, 6'h1D, 3'h3, 8'h00);
		`CK({skip_valid_o, skip_o}, 2'b10)
		io(3'h0, 6'h1D, 3'h0, 8'h00);
		`CK({io_rd_valid_o, io_rdata_o}, 9'h128)
		// a frozen clock enable must drop the io write
		@(posedge mclk_i);
		ce_i <= 1'b0;
		io(3'h1, 6'h1D, 3'h0, 8'h77);
		@(posedge mclk_i);
		ce_i <= 1'b1;
		io(3'h0, 6'h1D, 3'h0, 8'h00);
		`CK(io_rdata_o, 8'h28)
		@(posedge mclk_i);
		evt_i <= 8'h24;
		@(posedge mclk_i);
		evt_i <= 8'h00;
		io(3'h2, 6'h1C, 3'h2, 8'h00);
		io(3'h0, 6'h1C, 3'h0, 8'h00);
		`CK(io_rdata_o, 8'h20)
		rg(1'b1, 8'h3C, 8'h20);
		rg(1'b0, 8'h3C, 8'h00);
		`CK(reg_rdata_o, 8'h00)
		io(3'h2, 6'h20, 3'h0, 8'h00);
		`CK(io_err_o, 1'b1)
		rg(1'b1, 8'h60, 8'h5A);
		rg(1'b0, 8'h60, 8'h00);
		`CK(reg_rdata_o, 8'h5A)
		rg(1'b0, 8'h61, 8'h00);
		`CK(reg_rdata_o, 8'h00)
		$display("io and register test done");
		@(posedge mclk_i);
		req_valid_i <= 1'b1;
		req_i <= '0;
		@(posedge mclk_i);
		req_valid_i <= 1'b0;
		#1;
		`CK(res_o.valid, 1'b0)
		for (o = 1; o < 30; o++) begin
			for (i = 0; i < 4; i++) begin
				a = i == 0 ? 128 : $random(seed) & 255;
				b = i == 0 ? 128 : $random(seed) & 255;
				h = i == 0 ? 255 : $random(seed) & 255;
				ex(o, a, b, h);
			end
		end
		$display("execute test done");
		summarize();
	end
endmodule
`default_nettype wire

// ===== bench/exec_partner.sv
// register file side model: keeps product pair and pc written back
`timescale 1ns/10ps
`default_nettype none
module exec_partner (
	// clock
	input wire logic mclk_i,
	// results from the datapath
	input wire exec_pkg::exec_res_s res_i,
	// written back state
	output logic [15:0] pair_o,
	output logic [15:0] pc_o
);
	always_ff @(posedge mclk_i) begin
		if (res_i.valid && res_i.product) begin
			pair_o <= res_i.data;
		end
		if (res_i.valid && res_i.pc_load) begin
			pc_o <= res_i.data;
		end
	end
endmodule
`default_nettype wire

// ===== hw/arith_logic_execute.sv
// arithmetic, logic, multiply, pointer jump and io access execute unit
`timescale 1ns/10ps
`default_nettype none
module arith_logic_execute (
	// clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// execute request from the decoder
	input wire logic req_valid_i,
	input wire exec_pkg::exec_req_s req_i,
	output logic req_ready_o,
	// execute result to the register file and pc
	output exec_pkg::exec_res_s res_o,
	output logic [7:0] flags_o,
	// io instruction port
	input wire exec_pkg::io_cmd_s io_cmd_i,
	output logic [7:0] io_rdata_o,
	output logic io_rd_valid_o,
	output logic skip_o,
	output logic skip_valid_o,
	output logic io_err_o,
	// data space register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// peripheral events into the event register
	input wire logic [7:0] evt_i
);
	exec_pkg::exec_state_s s;
	exec_pkg::exec_state_s n;
	logic taken;
	logic two_cycle;
	logic is_mul;
	logic mul_a_signed;
	logic mul_b_signed;
	logic mul_frac;
	logic [15:0] mul_prod;
	logic mul_carry;

	function automatic logic [7:0] io_value(input logic [5:0] idx, input exec_pkg::exec_state_s st);
		logic [7:0] v;
		v = 8'h00;
		if (idx == exec_pkg::IO_FLAGS) begin
			v = st.sreg;
		end else if (idx == exec_pkg::IO_GP) begin
			v = st.gp;
		end else if (idx == exec_pkg::IO_EVENTS) begin
			v = st.evt;
		end
		return v;
	endfunction

	assign req_ready_o = (s.phase == exec_pkg::PH_IDLE);
	assign taken = req_valid_i & req_ready_o;

	always_comb begin
		is_mul = 1'b0;
		mul_a_signed = 1'b0;
		mul_b_signed = 1'b0;
		mul_frac = 1'b0;
		case (req_i.op)
			exec_pkg::OP_UNSIGNED_PRODUCT: begin
				is_mul = 1'b1;
			end
			exec_pkg::OP_SIGNED_PRODUCT: begin
				is_mul = 1'b1;
				mul_a_signed = 1'b1;
				mul_b_signed = 1'b1;
			end
			exec_pkg::OP_MIXED_SIGN_PRODUCT: begin
				is_mul = 1'b1;
				mul_a_signed = 1'b1;
			end
			exec_pkg::OP_FRACTION_PRODUCT_UNSIGNED: begin
				is_mul = 1'b1;
				mul_frac = 1'b1;
			end
			exec_pkg::OP_FRACTION_PRODUCT_SIGNED: begin
				is_mul = 1'b1;
				mul_a_signed = 1'b1;
				mul_b_signed = 1'b1;
				mul_frac = 1'b1;
			end
			exec_pkg::OP_FRACTION_PRODUCT_MIXED: begin
				is_mul = 1'b1;
				mul_a_signed = 1'b1;
				mul_frac = 1'b1;
			end
			default: begin
				is_mul = 1'b0;
			end
		endcase
		two_cycle = is_mul | (req_i.op == exec_pkg::OP_WORD_IMMEDIATE_PLUS)
			| (req_i.op == exec_pkg::OP_WORD_IMMEDIATE_MINUS)
			| (req_i.op == exec_pkg::OP_POINTER_JUMP);
	end

	mul_unit u_mul (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.ce_i(ce_i),
		.start_i(taken & is_mul),
		.a_i(req_i.rd),
		.b_i(req_i.rr),
		.a_signed_i(mul_a_signed),
		.b_signed_i(mul_b_signed),
		.frac_i(mul_frac),
		.prod_o(mul_prod),
		.carry_o(mul_carry)
	);

	always_comb begin
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] lres;
		logic [7:0] r;
		logic [8:0] sum;
		logic [16:0] w;
		logic [15:0] kw;
		logic [7:0] doff;
		logic [7:0] evt_clr;
		logic [7:0] bmask;
		logic [5:0] widx [2];
		logic [7:0] wdat [2];
		logic wen [2];
		logic cin;
		logic sub;
		logic arith;
		logic keep_ch;
		logic zkeep;
		logic inv_c;
		logic upd;
		logic reg_io;
		a = req_i.rd;
		b = req_i.rr;
		lres = 8'h00;
		r = 8'h00;
		sum = 9'h000;
		w = 17'h0_0000;
		kw = {10'h000, s.opk[5:0]};
		doff = reg_addr_i - exec_pkg::DATA_IO_OFFSET;
		evt_clr = 8'h00;
		bmask = 8'h01 << io_cmd_i.bitsel;
		cin = 1'b0;
		sub = 1'b0;
		arith = 1'b0;
		keep_ch = 1'b0;
		zkeep = 1'b0;
		inv_c = 1'b0;
		upd = 1'b1;
		n = s;
		n.res.valid = 1'b0;
		n.res.pc_load = 1'b0;
		n.io_rd_valid = 1'b0;
		n.skip_valid = 1'b0;
		n.io_err = 1'b0;

		// io registers seen in data space sit 0x20 above their io address
		reg_io = (reg_addr_i >= exec_pkg::DATA_IO_OFFSET) && (reg_addr_i < exec_pkg::DATA_EXT_BASE);
		wen[0] = reg_wr_i & reg_io;
		widx[0] = doff[5:0];
		wdat[0] = reg_wdata_i;
		wen[1] = 1'b0;
		widx[1] = io_cmd_i.addr;
		wdat[1] = io_cmd_i.wdata;

		if (reg_rd_i) begin
			if (reg_io) begin
				n.rdata = io_value(doff[5:0], s);
			end else if (reg_addr_i == exec_pkg::DATA_EXT_SCRATCH) begin
				n.rdata = s.scratch;
			end else begin
				n.rdata = 8'h00;
			end
		end
		if (reg_wr_i && (reg_addr_i == exec_pkg::DATA_EXT_SCRATCH)) begin
			n.scratch = reg_wdata_i;
		end

		if (io_cmd_i.valid) begin
			case (io_cmd_i.kind)
				exec_pkg::IO_IN: begin
					n.io_rdata = io_value(io_cmd_i.addr, s);
					n.io_rd_valid = 1'b1;
				end
				exec_pkg::IO_OUT: begin
					wen[1] = 1'b1;
				end
				default: begin
					// bit operations are refused above the bit-addressable range
					if (io_cmd_i.addr > exec_pkg::IO_BIT_LIMIT) begin
						n.io_err = 1'b1;
					end else if (io_cmd_i.kind == exec_pkg::IO_BIT_SET) begin
						wen[1] = 1'b1;
						// a lone one on the event byte clears just that flag
						wdat[1] = (io_cmd_i.addr == exec_pkg::IO_EVENTS) ? bmask
							: (io_value(io_cmd_i.addr, s) | bmask);
					end else if (io_cmd_i.kind == exec_pkg::IO_BIT_CLEAR) begin
						wen[1] = 1'b1;
						wdat[1] = (io_cmd_i.addr == exec_pkg::IO_EVENTS) ? 8'h00
							: (io_value(io_cmd_i.addr, s) & ~bmask);
					end else begin
						n.skip = ((io_value(io_cmd_i.addr, s) & bmask) != 8'h00)
							== (io_cmd_i.kind == exec_pkg::IO_SKIP_IF_BIT_ONE);
						n.skip_valid = 1'b1;
					end
				end
			endcase
		end

		for (int i = 0; i < 2; i++) begin
			if (wen[i]) begin
				if (widx[i] == exec_pkg::IO_FLAGS) begin
					n.sreg = wdat[i];
				end else if (widx[i] == exec_pkg::IO_GP) begin
					n.gp = wdat[i];
				end else if (widx[i] == exec_pkg::IO_EVENTS) begin
					evt_clr = evt_clr | wdat[i];
				end
			end
		end
		// a new event beats a clear in the same cycle
		n.evt = (s.evt & ~evt_clr) | evt_i;

		case (req_i.op)
			exec_pkg::OP_ADD: begin
				arith = 1'b1;
			end
			exec_pkg::OP_ADD_WITH_CARRY: begin
				arith = 1'b1;
				cin = s.sreg[exec_pkg::FLAG_C];
			end
			exec_pkg::OP_SUB: begin
				arith = 1'b1;
				sub = 1'b1;
			end
			exec_pkg::OP_DIFFERENCE_IMMEDIATE: begin
				arith = 1'b1;
				sub = 1'b1;
				b = req_i.k;
			end
			exec_pkg::OP_BORROW_DIFFERENCE_REGISTERS: begin
				arith = 1'b1;
				sub = 1'b1;
				cin = s.sreg[exec_pkg::FLAG_C];
				zkeep = 1'b1;
			end
			exec_pkg::OP_BORROW_DIFFERENCE_IMMEDIATE: begin
				arith = 1'b1;
				sub = 1'b1;
				b = req_i.k;
				cin = s.sreg[exec_pkg::FLAG_C];
				zkeep = 1'b1;
			end
			exec_pkg::OP_INCREMENT: begin
				arith = 1'b1;
				b = 8'h01;
				keep_ch = 1'b1;
			end
			exec_pkg::OP_DECREMENT: begin
				arith = 1'b1;
				sub = 1'b1;
				b = 8'h01;
				keep_ch = 1'b1;
			end
			exec_pkg::OP_ARITHMETIC_INVERSION: begin
				arith = 1'b1;
				sub = 1'b1;
				a = 8'h00;
				b = req_i.rd;
			end
			exec_pkg::OP_AND: lres = req_i.rd & req_i.rr;
			exec_pkg::OP_CONJUNCTION_IMMEDIATE: lres = req_i.rd & req_i.k;
			exec_pkg::OP_OR: lres = req_i.rd | req_i.rr;
			exec_pkg::OP_DISJUNCTION_IMMEDIATE: lres = req_i.rd | req_i.k;
			exec_pkg::OP_MASK_SET_BITS: lres = req_i.rd | req_i.k;
			exec_pkg::OP_MASK_CLEAR_BITS: lres = req_i.rd & (8'hFF - req_i.k);
			exec_pkg::OP_EXCLUSIVE_DISJUNCTION: lres = req_i.rd ^ req_i.rr;
			exec_pkg::OP_ZERO_SIGN_TEST: lres = req_i.rd & req_i.rd;
			exec_pkg::OP_CLEAR_REGISTER: lres = req_i.rd ^ req_i.rd;
			exec_pkg::OP_BITWISE_INVERT: begin
				lres = 8'hFF - req_i.rd;
				inv_c = 1'b1;
			end
			exec_pkg::OP_SET_REGISTER: begin
				lres = 8'hFF;
				upd = 1'b0;
			end
			default: upd = 1'b0;
		endcase
		// borrow shows up in bit 8 of the nine-bit difference
		sum = sub ? ({1'b0, a} - {1'b0, b} - {8'h00, cin}) : ({1'b0, a} + {1'b0, b} + {8'h00, cin});
		r = arith ? sum[7:0] : lres;

		if (taken && !two_cycle) begin
			n.res.valid = (req_i.op != exec_pkg::OP_NOP);
			n.res.word = 1'b0;
			n.res.product = 1'b0;
			n.res.data = {8'h00, r};
			if (upd) begin
				// borrow difference ops keep Z only if it was already set
				n.sreg[exec_pkg::FLAG_Z] = (r == 8'h00) & (~zkeep | s.sreg[exec_pkg::FLAG_Z]);
				n.sreg[exec_pkg::FLAG_N] = r[7];
				if (arith) begin
					n.sreg[exec_pkg::FLAG_V] = sub ? ((a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]))
						: ((a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]));
					if (!keep_ch) begin
						n.sreg[exec_pkg::FLAG_C] = sum[8];
						n.sreg[exec_pkg::FLAG_H] = sub ? ((~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]))
							: ((a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]));
					end
				end else begin
					n.sreg[exec_pkg::FLAG_V] = 1'b0;
					if (inv_c) begin
						n.sreg[exec_pkg::FLAG_C] = 1'b1;
					end
				end
				n.sreg[exec_pkg::FLAG_S] = n.sreg[exec_pkg::FLAG_N] ^ n.sreg[exec_pkg::FLAG_V];
			end
		end

		case (s.phase)
			exec_pkg::PH_IDLE: begin
				if (taken && two_cycle) begin
					n.phase = exec_pkg::PH_SECOND;
					n.op = req_i.op;
					n.opk = req_i.k;
					n.opa = (req_i.op == exec_pkg::OP_POINTER_JUMP) ? req_i.zptr : {req_i.rdh, req_i.rd};
				end
			end
			exec_pkg::PH_SECOND: begin
				n.phase = exec_pkg::PH_IDLE;
				n.res.valid = 1'b1;
				n.res.word = 1'b0;
				n.res.product = 1'b0;
				if (s.op == exec_pkg::OP_POINTER_JUMP) begin
					n.res.pc_load = 1'b1;
					n.res.data = s.opa;
				end else if ((s.op == exec_pkg::OP_WORD_IMMEDIATE_PLUS) || (s.op == exec_pkg::OP_WORD_IMMEDIATE_MINUS)) begin
					sub = (s.op == exec_pkg::OP_WORD_IMMEDIATE_MINUS);
					w = sub ? ({1'b0, s.opa} - {1'b0, kw}) : ({1'b0, s.opa} + {1'b0, kw});
					n.res.word = 1'b1;
					n.res.data = w[15:0];
					n.sreg[exec_pkg::FLAG_Z] = (w[15:0] == 16'h0000);
					n.sreg[exec_pkg::FLAG_N] = w[15];
					n.sreg[exec_pkg::FLAG_C] = sub ? (w[15] & ~s.opa[15]) : (~w[15] & s.opa[15]);
					n.sreg[exec_pkg::FLAG_V] = sub ? (s.opa[15] & ~w[15]) : (~s.opa[15] & w[15]);
					n.sreg[exec_pkg::FLAG_S] = w[15] ^ n.sreg[exec_pkg::FLAG_V];
				end else begin
					n.res.product = 1'b1;
					n.res.data = mul_prod;
					n.sreg[exec_pkg::FLAG_Z] = (mul_prod == 16'h0000);
					n.sreg[exec_pkg::FLAG_C] = mul_carry;
				end
			end
			default: n.phase = exec_pkg::PH_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			s <= '0;
			s.sreg <= exec_pkg::FLAGS_RST;
			s.gp <= exec_pkg::GP_RST;
			s.evt <= exec_pkg::EVENTS_RST;
			s.scratch <= exec_pkg::SCRATCH_RST;
		end else if (ce_i) begin
			s <= n;
		end
	end

	assign res_o = s.res;
	assign flags_o = s.sreg;
	assign io_rdata_o = s.io_rdata;
	assign io_rd_valid_o = s.io_rd_valid;
	assign skip_o = s.skip;
	assign skip_valid_o = s.skip_valid;
	assign io_err_o = s.io_err;
	assign reg_rdata_o = s.rdata;

	AST_ADD_CARRY_SUM: assert property (@(posedge mclk_i) disable iff (srst_i || !ce_i)
		taken && req_i.op == exec_pkg::OP_ADD_WITH_CARRY |=> res_o.valid
		&& res_o.data[7:0] == 8'($past(req_i.rd) + $past(req_i.rr) + 8'($past(s.sreg[0]))))
		else $error("add with carry gives wrong sum or timing");
	AST_WORD_PLUS_TWO: assert property (@(posedge mclk_i) disable iff (srst_i || !ce_i)
		taken && req_i.op == exec_pkg::OP_WORD_IMMEDIATE_PLUS |=> !res_o.valid ##1 res_o.valid
		&& res_o.word && res_o.data == 16'({$past(req_i.rdh, 2), $past(req_i.rd, 2)} + {10'h000, $past(req_i.k[5:0], 2)}))
		else $error("word add result not after two clocks");
	AST_WORD_MINUS_S: assert property (@(posedge mclk_i) disable iff (srst_i || !ce_i)
		taken && req_i.op == exec_pkg::OP_WORD_IMMEDIATE_MINUS |-> ##2 res_o.valid && res_o.word
		&& res_o.data == 16'({$past(req_i.rdh, 2), $past(req_i.rd, 2)} - {10'h000, $past(req_i.k[5:0], 2)})
		&& flags_o[exec_pkg::FLAG_S] == (flags_o[exec_pkg::FLAG_N] ^ flags_o[exec_pkg::FLAG_V]))
		else $error("word subtract flags or timing wrong");
	AST_DIFF_IMM: assert property (@(posedge mclk_i) disable iff (srst_i || !ce_i)
		taken && req_i.op == exec_pkg::OP_DIFFERENCE_IMMEDIATE |=> res_o.valid
		&& res_o.data[7:0] == 8'($past(req_i.rd) - $past(req_i.k))
		&& flags_o[exec_pkg::FLAG_C] == ($past(req_i.k) > $past(req_i.rd)))
		else $error("immediate difference or borrow wrong");
	AST_BORROW_Z_STICKY: assert property (@(posedge mclk_i) disable iff (srst_i || !ce_i)
		taken && req_i.op == exec_pkg::OP_BORROW_DIFFERENCE_REGISTERS && !s.sreg[exec_pkg::FLAG_Z]
		|=> !flags_o[exec_pkg::FLAG_Z])
		else $error("borrow difference set Z from a cleared Z");
	AST_AND_IMM_KEEPS_C: assert property (@(posedge mclk_i) disable iff (srst_i || !ce_i)
		taken && req_i.op == exec_pkg::OP_CONJUNCTION_IMMEDIATE |=> !flags_o[exec_pkg::FLAG_V]
		&& flags_o[exec_pkg::FLAG_C] == $past(s.sreg[exec_pkg::FLAG_C])
		&& flags_o[exec_pkg::FLAG_H] == $past(s.sreg[exec_pkg::FLAG_H]))
		else $error("and immediate touched C, H or left V set");
	AST_MASK_CLEAR: assert property (@(posedge mclk_i) disable iff (srst_i || !ce_i)
		taken && req_i.op == exec_pkg::OP_MASK_CLEAR_BITS |=> res_o.data[7:0] == ($past(req_i.rd) & ~$past(req_i.k)))
		else $error("mask clear result wrong");
	AST_UNSIGNED_PRODUCT: assert property (@(posedge mclk_i) disable iff (srst_i || !ce_i)
		taken && req_i.op == exec_pkg::OP_UNSIGNED_PRODUCT |-> ##2 res_o.valid && res_o.product
		&& res_o.data == ({8'h00, $past(req_i.rd, 2)} * {8'h00, $past(req_i.rr, 2)}))
		else $error("unsigned product wrong or late");
	AST_POINTER_JUMP: assert property (@(posedge mclk_i) disable iff (srst_i || !ce_i)
		taken && req_i.op == exec_pkg::OP_POINTER_JUMP |-> ##2 res_o.pc_load
		&& res_o.data == $past(req_i.zptr, 2) && flags_o == $past(s.sreg, 1))
		else $error("pointer jump pc or flags wrong");
	AST_BIT_OP_RANGE: assert property (@(posedge mclk_i) disable iff (srst_i || !ce_i)
		io_cmd_i.valid && io_cmd_i.kind == exec_pkg::IO_BIT_SET && io_cmd_i.addr > exec_pkg::IO_BIT_LIMIT
		&& !(taken && req_i.op != exec_pkg::OP_NOP) && req_ready_o |=> io_err_o && $stable(flags_o))
		else $error("bit set above 0x1F was not refused");
endmodule
`default_nettype wire

// ===== hw/exec_pkg.sv
// shared types and constants of the arithmetic and logic execute datapath
package exec_pkg;

	typedef enum logic [4:0] {
		OP_NOP = 5'h00,
		OP_ADD = 5'h01,
		OP_ADD_WITH_CARRY = 5'h02,
		OP_WORD_IMMEDIATE_PLUS = 5'h03,
		OP_SUB = 5'h04,
		OP_DIFFERENCE_IMMEDIATE = 5'h05,
		OP_BORROW_DIFFERENCE_REGISTERS = 5'h06,
		OP_BORROW_DIFFERENCE_IMMEDIATE = 5'h07,
		OP_WORD_IMMEDIATE_MINUS = 5'h08,
		OP_AND = 5'h09,
		OP_CONJUNCTION_IMMEDIATE = 5'h0A,
		OP_OR = 5'h0B,
		OP_DISJUNCTION_IMMEDIATE = 5'h0C,
		OP_EXCLUSIVE_DISJUNCTION = 5'h0D,
		OP_BITWISE_INVERT = 5'h0E,
		OP_ARITHMETIC_INVERSION = 5'h0F,
		OP_MASK_SET_BITS = 5'h10,
		OP_MASK_CLEAR_BITS = 5'h11,
		OP_INCREMENT = 5'h12,
		OP_DECREMENT = 5'h13,
		OP_ZERO_SIGN_TEST = 5'h14,
		OP_CLEAR_REGISTER = 5'h15,
		OP_SET_REGISTER = 5'h16,
		OP_UNSIGNED_PRODUCT = 5'h17,
		OP_SIGNED_PRODUCT = 5'h18,
		OP_MIXED_SIGN_PRODUCT = 5'h19,
		OP_FRACTION_PRODUCT_UNSIGNED = 5'h1A,
		OP_FRACTION_PRODUCT_SIGNED = 5'h1B,
		OP_FRACTION_PRODUCT_MIXED = 5'h1C,
		OP_POINTER_JUMP = 5'h1D
	} exec_op_e;

	typedef enum logic [2:0] {
		IO_IN = 3'h0,
		IO_OUT = 3'h1,
		IO_BIT_SET = 3'h2,
		IO_BIT_CLEAR = 3'h3,
		IO_SKIP_IF_BIT_ONE = 3'h4,
		IO_SKIP_IF_BIT_ZERO = 3'h5
	} io_kind_e;

	typedef enum logic {
		PH_IDLE = 1'b0,
		PH_SECOND = 1'b1
	} exec_phase_e;

	// flag positions in the status byte
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;

	// io and data space map
	localparam logic [5:0] IO_FLAGS = 6'h3F;
	localparam logic [5:0] IO_GP = 6'h1D;
	localparam logic [5:0] IO_EVENTS = 6'h1C;
	localparam logic [5:0] IO_BIT_LIMIT = 6'h1F;
	localparam logic [7:0] DATA_IO_OFFSET = 8'h20;
	localparam logic [7:0] DATA_EXT_BASE = 8'h60;
	localparam logic [7:0] DATA_EXT_SCRATCH = 8'h60;

	// values after reset
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [7:0] GP_RST = 8'h00;
	localparam logic [7:0] EVENTS_RST = 8'h00;
	localparam logic [7:0] SCRATCH_RST = 8'h00;

	typedef struct packed {
		exec_op_e op;
		logic [7:0] rd;
		logic [7:0] rr;
		logic [7:0] rdh;
		logic [7:0] k;
		logic [15:0] zptr;
	} exec_req_s;

	typedef struct packed {
		logic valid;
		logic word;
		logic product;
		logic pc_load;
		logic [15:0] data;
	} exec_res_s;

	typedef struct packed {
		logic valid;
		io_kind_e kind;
		logic [5:0] addr;
		logic [2:0] bitsel;
		logic [7:0] wdata;
	} io_cmd_s;

	typedef struct packed {
		logic [15:0] prod;
		logic carry;
	} mul_state_s;

	typedef struct packed {
		exec_phase_e phase;
		exec_op_e op;
		logic [15:0] opa;
		logic [7:0] opk;
		logic [7:0] sreg;
		exec_res_s res;
		logic [7:0] gp;
		logic [7:0] evt;
		logic [7:0] scratch;
		logic [7:0] rdata;
		logic [7:0] io_rdata;
		logic io_rd_valid;
		logic skip;
		logic skip_valid;
		logic io_err;
	} exec_state_s;

endpackage

// ===== hw/mul_unit.sv
// single-stage multiplier, product registered one clock after start, with signed, mixed and fractional variants
`timescale 1ns/10ps
`default_nettype none
module mul_unit (
	// clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// operands
	input wire logic start_i,
	input wire logic [7:0] a_i,
	input wire logic [7:0] b_i,
	input wire logic a_signed_i,
	input wire logic b_signed_i,
	input wire logic frac_i,
	// product
	output logic [15:0] prod_o,
	output logic carry_o
);
	exec_pkg::mul_state_s s;
	exec_pkg::mul_state_s n;
	logic signed [8:0] sa;
	logic signed [8:0] sb;
	logic signed [17:0] full;
	logic [15:0] raw;

	always_comb begin
		n = s;
		sa = $signed({a_signed_i & a_i[7], a_i});
		sb = $signed({b_signed_i & b_i[7], b_i});
		full = sa * sb;
		raw = full[15:0];
		if (start_i) begin
			// carry takes bit 15 before the fractional shift
			n.prod = frac_i ? {raw[14:0], 1'b0} : raw;
			n.carry = raw[15];
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			s <= '0;
		end else if (ce_i) begin
			s <= n;
		end
	end

	assign prod_o = s.prod;
	assign carry_o = s.carry;
endmodule
`default_nettype wire
